// File: analog_pin_pkg.sv
package analog_pin_pkg;
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam int NUM_CH = 24;
  localparam int REG_W = 8;
  localparam logic [ADDR_W-1:0] OFS_DISABLE_LOW = 2'h0;
  localparam logic [ADDR_W-1:0] OFS_DISABLE_MID = 2'h1;
  localparam logic [ADDR_W-1:0] OFS_DISABLE_HIGH = 2'h2;
  localparam logic [REG_W-1:0] RST_DISABLE = 8'h00;
  localparam logic [DATA_W-1:0] RD_UNMAPPED = 8'h00;
  localparam logic [NUM_CH-1:0] DEF_CH_PRESENT = 24'hFFFFFF;
endpackage : analog_pin_pkg

// File: pin_gate.sv
`timescale 1ns/10ps
// one pad's digital gating, purely combinational
module pin_gate (
  input wire logic disable_in,
  input wire logic port_out_in,
  input wire logic port_dir_in,
  input wire logic port_pull_in,
  input wire logic pad_sync_in,
  output logic pad_out_out,
  output logic pad_oe_n_out,
  output logic pad_pull_out,
  output logic port_rd_out
);
  always_comb begin
    pad_out_out = port_out_in & ~disable_in;
    pad_oe_n_out = ~port_dir_in | disable_in;
    pad_pull_out = port_pull_in & ~disable_in;
    port_rd_out = pad_sync_in & ~disable_in;
  end
endmodule : pin_gate

// File: analog_pin_digital_disable.sv
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module analog_pin_digital_disable
  import analog_pin_pkg::*;
#(
  parameter logic [analog_pin_pkg::NUM_CH-1:0] CH_PRESENT =
    analog_pin_pkg::DEF_CH_PRESENT,
  parameter bit HAS_MID = 1'b1,
  parameter bit HAS_HIGH = 1'b1
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [analog_pin_pkg::ADDR_W-1:0] addr_in,
  input wire logic [analog_pin_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [analog_pin_pkg::DATA_W-1:0] rdata_out,
  input wire logic [analog_pin_pkg::NUM_CH-1:0] port_out_in,
  input wire logic [analog_pin_pkg::NUM_CH-1:0] port_dir_in,
  input wire logic [analog_pin_pkg::NUM_CH-1:0] port_pull_in,
  input wire logic [analog_pin_pkg::NUM_CH-1:0] pad_in,
  output logic [analog_pin_pkg::NUM_CH-1:0] pad_out_out,
  output logic [analog_pin_pkg::NUM_CH-1:0] pad_oe_n_out,
  output logic [analog_pin_pkg::NUM_CH-1:0] pad_pull_out,
  output logic [analog_pin_pkg::NUM_CH-1:0] port_rd_out,
  output logic [analog_pin_pkg::NUM_CH-1:0] analog_sel_out
);
  import analog_pin_pkg::*;

  // parameter values the logic cannot serve are refused here
  generate
    if (NUM_CH != 3 * REG_W) begin : g_bad_count
      $error("channel count must equal three registers of bits");
    end
    if (DATA_W != REG_W) begin : g_bad_width
      $error("bus data width must equal register width");
    end
    if (ADDR_W < 2) begin : g_bad_addr
      $error("address must reach all three registers");
    end
    if (!HAS_MID && (CH_PRESENT[2*REG_W-1:REG_W] != '0)) begin : g_bad_mid
      $error("channels of the mid register need that register");
    end
    if (!HAS_HIGH && (CH_PRESENT[3*REG_W-1:2*REG_W] != '0))
    begin : g_bad_high
      $error("channels of the high register need that register");
    end
  endgenerate

  logic [REG_W-1:0] dis_low;
  logic [REG_W-1:0] dis_mid;
  logic [REG_W-1:0] dis_high;
  logic [REG_W-1:0] next_dis_low;
  logic [REG_W-1:0] next_dis_mid;
  logic [REG_W-1:0] next_dis_high;
  logic wr_low;
  logic wr_mid;
  logic wr_high;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;
  logic [NUM_CH-1:0] pad_meta;
  logic [NUM_CH-1:0] pad_sync;
  logic [NUM_CH-1:0] next_pad_meta;
  logic [NUM_CH-1:0] next_pad_sync;
  logic [NUM_CH-1:0] dis_vec;
  logic [NUM_CH-1:0] pad_out_c;
  logic [NUM_CH-1:0] pad_oe_n_c;
  logic [NUM_CH-1:0] pad_pull_c;
  logic [NUM_CH-1:0] port_rd_c;
  logic [NUM_CH-1:0] out_q;
  logic [NUM_CH-1:0] oe_n_q;
  logic [NUM_CH-1:0] pull_q;
  logic [NUM_CH-1:0] rd_q;
  logic [NUM_CH-1:0] ana_q;
  logic [NUM_CH-1:0] next_out;
  logic [NUM_CH-1:0] next_oe_n;
  logic [NUM_CH-1:0] next_pull;
  logic [NUM_CH-1:0] next_rd;
  logic [NUM_CH-1:0] next_ana;

  // write decode; an absent register never takes a write
  always_comb begin
    wr_low = 1'b0;
    wr_mid = 1'b0;
    wr_high = 1'b0;
    if (wr_in) begin
      case (addr_in)
        OFS_DISABLE_LOW: wr_low = 1'b1;
        OFS_DISABLE_MID: wr_mid = HAS_MID;
        OFS_DISABLE_HIGH: wr_high = HAS_HIGH;
        default: begin
        end
      endcase
    end
  end

  // register file
  always_comb begin
    next_dis_low = dis_low;
    next_dis_mid = dis_mid;
    next_dis_high = dis_high;
    if (wr_low) begin
      next_dis_low = wdata_in;
    end
    if (wr_mid) begin
      next_dis_mid = wdata_in;
    end
    if (wr_high) begin
      next_dis_high = wdata_in;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dis_low <= RST_DISABLE;
      dis_mid <= RST_DISABLE;
      dis_high <= RST_DISABLE;
    end else begin
      dis_low <= next_dis_low;
      dis_mid <= next_dis_mid;
      dis_high <= next_dis_high;
    end
  end

  // read data stands one cycle only, zero otherwise
  always_comb begin
    next_rdata = RD_UNMAPPED;
    if (rd_in) begin
      case (addr_in)
        OFS_DISABLE_LOW: next_rdata = dis_low;
        OFS_DISABLE_MID: next_rdata = HAS_MID ? dis_mid : RD_UNMAPPED;
        OFS_DISABLE_HIGH: next_rdata = HAS_HIGH ? dis_high : RD_UNMAPPED;
        default: next_rdata = RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata <= RD_UNMAPPED;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign rdata_out = rdata;

  // register bits to channels; absent channels never gate a pin
  genvar bt;
  generate
    for (bt = 0; bt < REG_W; bt++) begin : g_map
      assign dis_vec[bt] = dis_low[bt] & CH_PRESENT[bt];
      assign dis_vec[REG_W+bt] =
        dis_mid[bt] & CH_PRESENT[REG_W+bt];
      assign dis_vec[2*REG_W+bt] =
        dis_high[bt] & CH_PRESENT[2*REG_W+bt];
    end
  endgenerate

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_pin
      pin_gate u_gate (
        .disable_in(dis_vec[ch]),
        .port_out_in(port_out_in[ch]),
        .port_dir_in(port_dir_in[ch]),
        .port_pull_in(port_pull_in[ch]),
        .pad_sync_in(pad_sync[ch]),
        .pad_out_out(pad_out_c[ch]),
        .pad_oe_n_out(pad_oe_n_c[ch]),
        .pad_pull_out(pad_pull_c[ch]),
        .port_rd_out(port_rd_c[ch])
      );
    end
  endgenerate

  // two-stage synchroniser for the raw pad levels
  always_comb begin
    next_pad_meta = pad_in;
    next_pad_sync = pad_meta;
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pad_meta <= '0;
      pad_sync <= '0;
    end else begin
      pad_meta <= next_pad_meta;
      pad_sync <= next_pad_sync;
    end
  end

  // outputs come from flops so pads never see gating glitches
  always_comb begin
    next_out = pad_out_c;
    next_oe_n = pad_oe_n_c;
    next_pull = pad_pull_c;
    next_rd = port_rd_c;
    next_ana = dis_vec;
  end

  // reset leaves every driver off and every pin digital
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_q <= '0;
      oe_n_q <= '1;
      pull_q <= '0;
      rd_q <= '0;
      ana_q <= '0;
    end else begin
      out_q <= next_out;
      oe_n_q <= next_oe_n;
      pull_q <= next_pull;
      rd_q <= next_rd;
      ana_q <= next_ana;
    end
  end

  assign pad_out_out = out_q;
  assign pad_oe_n_out = oe_n_q;
  assign pad_pull_out = pull_q;
  assign port_rd_out = rd_q;
  assign analog_sel_out = ana_q;
endmodule : analog_pin_digital_disable

// File: analog_pin_properties.sv
`timescale 1ns/10ps
module analog_pin_checker (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [1:0] addr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic [23:0] port_dir_in,
  input wire logic [23:0] port_pull_in,
  input wire logic [23:0] pad_oe_n_out,
  input wire logic [23:0] pad_pull_out,
  input wire logic [23:0] port_rd_out,
  input wire logic [23:0] analog_sel_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  a_reset_clear: assert property (
    !$past(rst_n_in) |-> analog_sel_out == 24'h0) else $error("rst");
  a_low_map: assert property (
    rd_in && addr_in == 2'h0 |=> rdata_out == analog_sel_out[7:0])
    else $error("low");
  a_mid_map: assert property (
    rd_in && addr_in == 2'h1 |=> rdata_out == analog_sel_out[15:8])
    else $error("mid");
  a_high_map: assert property (
    rd_in && addr_in == 2'h2 |=> rdata_out == analog_sel_out[23:16])
    else $error("high");
  a_hole_zero: assert property (
    rd_in && addr_in == 2'h3 |=> rdata_out == 8'h00) else $error("hole");
  a_oe_follow: assert property ($past(rst_n_in) |->
    pad_oe_n_out == ~($past(port_dir_in) & ~analog_sel_out))
    else $error("oe");
  a_pull_off: assert property ($past(rst_n_in) |->
    pad_pull_out == ($past(port_pull_in) & ~analog_sel_out))
    else $error("pull");
  a_read_gated: assert property (
    (port_rd_out & analog_sel_out) == 24'h0) else $error("rd");
  cover property (rd_in && addr_in == 2'h3);
  cover property (rd_in && addr_in == 2'h2);
  cover property ($fell(analog_sel_out[23]));
endmodule : analog_pin_checker
bind analog_pin_digital_disable analog_pin_checker chk_i (.*);

// File: testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clock_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0;
  logic [1:0] addr_in = 2'h0;
  logic [7:0] wdata_in = 8'h00, rdata_out;
  logic [23:0] port_out_in = 0, port_dir_in = 0, port_pull_in = 0;
  logic [23:0] pad_in = 0, pad_out_out, pad_oe_n_out, pad_pull_out;
  logic [23:0] port_rd_out, analog_sel_out, sel;
  logic [7:0] m [4] = '{default: 8'h00};
  int err_count = 0, comparisons = 0, seed = 11, a, d;
  analog_pin_digital_disable uut (.*);
  initial begin
    forever #12.5 clock_in = ~clock_in;
  end
  task chk(input logic [23:0] s, e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task give_verdict;
    $display("err_count %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    #100000;
    err_count++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge clock_in);
    rst_n_in <= 1;
    for (int i = 0; i < 300; i++) begin
      @(posedge clock_in);
      if (i % 2 == 0) a = $random(seed) & 3;
      d = $random(seed);
      addr_in <= a[1:0];
      wdata_in <= d[7:0];
      {wr_in, rd_in} <= (i % 2) ? 2'b01 : 2'b10;
      if (i % 2 == 0 && a < 3) m[a] = d[7:0];
      port_out_in <= 24'($random(seed));
      port_dir_in <= 24'($random(seed));
      port_pull_in <= 24'($random(seed));
      pad_in <= 24'($random(seed));
      @(posedge clock_in);
      {wr_in, rd_in} <= 2'b00;
      #1;
      if (i % 2) chk(rdata_out, m[a]);
      repeat (3) @(posedge clock_in);
      #1;
      sel = {m[2], m[1], m[0]};
      chk(analog_sel_out, sel);
      chk(pad_oe_n_out, ~(port_dir_in & ~sel));
      chk(pad_out_out, port_out_in & ~sel);
      chk(pad_pull_out, port_pull_in & ~sel);
      chk(port_rd_out, pad_in & ~sel);
    end
    rst_n_in <= 0;
    @(posedge clock_in);
    #1;
    chk(analog_sel_out, 24'h0);
    give_verdict();
  end
endmodule : testbench
